// ---- tsfc_pkg.sv ----
// Constants, field layouts and carrier types for the start-up and fail-safe clock block.
// Assumes one 10 MHz system clock; every other clock reaches the block as a sampled pin.
`default_nettype none

package tsfc_pkg;

    // =====================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WARM_NS = 2000;
    localparam int WARM_CYC = (T_WARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_PLL_LOCK_NS = 2000000;
    localparam int PLL_LOCK_CYC_DEF = (T_PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] WARM_LAST = 8'(WARM_CYC - 1);
    localparam int OST_COUNT = 1024;
    localparam logic [10:0] OST_LAST = 11'(OST_COUNT - 1);
    localparam logic [5:0] SAMP_RISE_AT = 6'h1f;
    localparam logic [5:0] SAMP_FALL_AT = 6'h3f;

    // =====================================================================
    // Register map
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_FLAG = 8'h08;
    localparam logic [7:0] OFF_IE = 8'h0c;
    localparam int STAT_STARTUP_TIMEOUT_STATUS = 0;
    localparam int STAT_FAILSAFE = 1;
    localparam int STAT_SEL_EXT = 2;
    localparam int STAT_PLL_READY = 3;
    localparam int FLAG_BIT = 0;
    localparam int IE_BIT = 0;
    localparam int CTRL_RSVD_BIT = 2;

    localparam logic [1:0] SCS_CFG = 2'h0;
    localparam logic [1:0] SCS_T1 = 2'h1;
    localparam int SCS_INT_BIT = 1;
    localparam logic [3:0] IFS_RST = 4'h7;
    localparam logic [3:0] IFS_32M = 4'he;
    localparam logic [2:0] IFS_LF_HI = 3'h0;
    localparam int IFS_HF_BIT = 3;

    localparam logic [2:0] MODE_LP = 3'h0;
    localparam logic [2:0] MODE_XT = 3'h1;
    localparam logic [2:0] MODE_HS = 3'h2;
    localparam logic [2:0] MODE_EC = 3'h3;
    localparam logic [2:0] MODE_INT = 3'h4;
    localparam logic [2:0] MODE_RC = 3'h5;

    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_CFG = 2'h1;
    localparam logic [1:0] SRC_T1 = 2'h2;

    // =====================================================================
    // Types
    typedef enum logic [2:0] {
        ST_POWERUP_TIMER, ST_WARM, ST_OST, ST_WAIT_INT, ST_HOLD, ST_EXT, ST_INT, ST_SLEEP
    } tsfc_state_t;

    typedef enum logic [1:0] {BAND_LF, BAND_MF, BAND_HF} tsfc_band_t;

    typedef struct packed {
        logic soft_pll_enable;
        logic [3:0] ifs;
        logic rsvd;
        logic [1:0] system_clock_select;
    } tsfc_ctrl_t;

    localparam tsfc_ctrl_t CTRL_RST = '{soft_pll_enable: 1'b0, ifs: IFS_RST, rsvd: 1'b0, system_clock_select: SCS_CFG};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tsfc_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tsfc_apb_rsp_t;

    typedef struct packed {
        logic internal_external_switchover;
        logic failsafe_monitor_enable;
        logic config_pll_enable;
        logic powerup_timer_en;
        logic [2:0] osc_mode;
    } tsfc_cfg_t;

    typedef struct packed {
        tsfc_state_t st;
        tsfc_ctrl_t ctrl;
        logic [1:0] scs_prev;
        logic flag;
        logic ie;
        logic failsafe;
        logic startup_timeout_status;
        logic [1:0] src;
        logic sel_ext;
        logic clk_hold;
        logic cpu_hold;
        logic pll_on;
        logic pll_ready;
        logic [14:0] pll_cnt;
        tsfc_band_t band;
        logic f32m;
        logic irq;
        logic [2:0] ext_s;
        logic [2:0] int_s;
        logic [2:0] lf_s;
        logic [5:0] div;
        logic latch;
        logic [10:0] ost_cnt;
        logic [7:0] warm_cnt;
        tsfc_apb_rsp_t rsp;
    } tsfc_st_t;

endpackage

`default_nettype wire

// ---- tsfc_top.sv ----
// Two-speed start-up sequencer, fail-safe clock monitor and oscillator control register.
// Assumes an APB master on i_mclk, configuration bits that are static, and the three
// oscillator clocks arriving as pins that are far slower than i_mclk.
`default_nettype none

module tsfc_top
    import tsfc_pkg::*;
#(
    parameter int PLL_LOCK_CYC = PLL_LOCK_CYC_DEF
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire tsfc_apb_req_t i_apb,
    output tsfc_apb_rsp_t o_apb,
    input wire tsfc_cfg_t i_cfg,
    input wire logic i_ext_clk,
    input wire logic i_int_clk,
    input wire logic i_lf_clk,
    input wire logic i_powerup_timer_done,
    input wire logic i_sleep,
    input wire logic i_wake,
    output logic o_sel_ext,
    output logic o_clk_hold,
    output logic [1:0] o_clk_src,
    output logic o_startup_timeout_status,
    output logic o_failsafe,
    output logic o_cpu_hold,
    output logic o_pll_on,
    output logic o_pll_ready,
    output logic [3:0] o_freq_sel,
    output tsfc_band_t o_band,
    output logic o_f32m,
    output logic o_irq
);

    tsfc_st_t cur;
    tsfc_st_t nxt;

    logic ext_fall;
    logic int_fall;
    logic lf_rise;
    logic samp_rise;
    logic samp_fall;
    logic xtal;
    logic ts_en;
    logic mon_on;
    logic fail;
    logic start;
    logic acc;
    logic wr_now;
    logic flag_clr;

    function automatic tsfc_band_t band_of(input logic [3:0] ifs);
        if (ifs[IFS_HF_BIT]) begin
            band_of = BAND_HF;
        end else if (ifs[3:1] == IFS_LF_HI) begin
            band_of = BAND_LF;
        end else begin
            band_of = BAND_MF;
        end
    endfunction

    // =====================================================================
    // Next-state logic
    always_comb begin
        nxt = cur;
        start = 1'b0;
        // The pins are sampled by i_mclk, so an external clock must stay well below 5 MHz.
        nxt.ext_s = {cur.ext_s[1:0], i_ext_clk};
        nxt.int_s = {cur.int_s[1:0], i_int_clk};
        nxt.lf_s = {cur.lf_s[1:0], i_lf_clk};
        ext_fall = cur.ext_s[2] & ~cur.ext_s[1];
        int_fall = cur.int_s[2] & ~cur.int_s[1];
        lf_rise = ~cur.lf_s[2] & cur.lf_s[1];
        if (lf_rise) begin
            nxt.div = cur.div + 6'h01;
        end
        samp_rise = lf_rise && (cur.div == SAMP_RISE_AT);
        samp_fall = lf_rise && (cur.div == SAMP_FALL_AT);
        if (samp_rise) begin
            nxt.latch = 1'b0;
        end
        if (ext_fall) begin
            nxt.latch = 1'b1;
        end
        xtal = (i_cfg.osc_mode == MODE_LP) || (i_cfg.osc_mode == MODE_XT)
            || (i_cfg.osc_mode == MODE_HS);
        ts_en = (i_cfg.internal_external_switchover || i_cfg.failsafe_monitor_enable) && (cur.ctrl.system_clock_select == SCS_CFG) && xtal;
        mon_on = i_cfg.failsafe_monitor_enable && (cur.st == ST_EXT) && !cur.failsafe;
        // A low external edge in the checking cycle itself still counts as alive.
        fail = mon_on && samp_fall && !cur.latch && !ext_fall;
        case (cur.st)
            ST_POWERUP_TIMER: begin
                if (!i_cfg.powerup_timer_en || i_powerup_timer_done) begin
                    start = 1'b1;
                end
            end
            ST_WARM: begin
                nxt.warm_cnt = cur.warm_cnt + 8'h01;
                if (cur.warm_cnt == WARM_LAST) begin
                    nxt.st = ST_OST;
                end
            end
            ST_OST: begin
                if (ext_fall) begin
                    nxt.ost_cnt = cur.ost_cnt + 11'h001;
                    if (cur.ost_cnt == OST_LAST) begin
                        nxt.st = ST_WAIT_INT;
                    end
                end
            end
            ST_WAIT_INT: begin
                if (int_fall) begin
                    nxt.startup_timeout_status = 1'b1;
                    nxt.clk_hold = 1'b1;
                    nxt.st = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ext_fall) begin
                    nxt.clk_hold = 1'b0;
                    nxt.st = ST_EXT;
                    nxt.src = SRC_CFG;
                    nxt.failsafe = 1'b0;
                end
            end
            ST_EXT: begin
                if (fail) begin
                    nxt.failsafe = 1'b1;
                    nxt.st = ST_INT;
                    nxt.src = SRC_INT;
                    nxt.startup_timeout_status = 1'b0;
                end
            end
            ST_INT: begin
                nxt.st = ST_INT;
            end
            ST_SLEEP: begin
                if (i_wake) begin
                    start = 1'b1;
                end
            end
            default: begin
                nxt.st = ST_POWERUP_TIMER;
            end
        endcase
        nxt.scs_prev = cur.ctrl.system_clock_select;
        if ((cur.ctrl.system_clock_select != cur.scs_prev) && (cur.st != ST_SLEEP) && (cur.st != ST_POWERUP_TIMER)) begin
            start = 1'b1;
        end
        if (start) begin
            nxt.startup_timeout_status = 1'b0;
            nxt.clk_hold = 1'b0;
            nxt.warm_cnt = '0;
            nxt.ost_cnt = '0;
            nxt.src = SRC_INT;
            if (cur.ctrl.system_clock_select[SCS_INT_BIT]) begin
                nxt.st = ST_INT;
                nxt.failsafe = 1'b0;
            end else if (cur.ctrl.system_clock_select == SCS_T1) begin
                nxt.st = ST_EXT;
                nxt.src = SRC_T1;
                nxt.failsafe = 1'b0;
            end else if (xtal) begin
                // Fail-safe stays set until the restarted start-up switches to the external clock in ST_HOLD.
                nxt.st = ST_WARM;
            end else if (i_cfg.osc_mode == MODE_INT) begin
                nxt.st = ST_INT;
                nxt.failsafe = 1'b0;
            end else begin
                nxt.st = ST_EXT;
                nxt.src = SRC_CFG;
                nxt.startup_timeout_status = 1'b1;
                nxt.failsafe = 1'b0;
            end
        end
        if (i_sleep) begin
            nxt.st = ST_SLEEP;
            nxt.startup_timeout_status = 1'b0;
            nxt.failsafe = 1'b0;
            nxt.clk_hold = 1'b0;
        end
        // Without two-speed start-up the core waits for the timer instead of running.
        nxt.cpu_hold = !ts_en && ((nxt.st == ST_WARM) || (nxt.st == ST_OST)
            || (nxt.st == ST_WAIT_INT) || (nxt.st == ST_HOLD));
        nxt.sel_ext = (nxt.st == ST_EXT);
        // =================================================================
        // APB slave: one wait state; read data is captured on the edge that raises ready, the write on the edge that ends the transfer.
        acc = i_apb.psel && i_apb.penable && !cur.rsp.pready;
        wr_now = i_apb.psel && i_apb.penable && i_apb.pwrite && cur.rsp.pready;
        nxt.rsp = '0;
        if (acc) begin
            nxt.rsp.pready = 1'b1;
            case (i_apb.paddr)
                OFF_CTRL: begin
                    nxt.rsp.prdata[7:0] = cur.ctrl;
                    nxt.rsp.prdata[CTRL_RSVD_BIT] = 1'b0;
                end
                OFF_STAT: begin
                    nxt.rsp.prdata[STAT_STARTUP_TIMEOUT_STATUS] = cur.startup_timeout_status;
                    nxt.rsp.prdata[STAT_FAILSAFE] = cur.failsafe;
                    nxt.rsp.prdata[STAT_SEL_EXT] = cur.sel_ext;
                    nxt.rsp.prdata[STAT_PLL_READY] = cur.pll_ready;
                end
                OFF_FLAG: begin
                    nxt.rsp.prdata[FLAG_BIT] = cur.flag;
                end
                OFF_IE: begin
                    nxt.rsp.prdata[IE_BIT] = cur.ie;
                end
                default: begin
                    nxt.rsp.pslverr = 1'b1;
                end
            endcase
        end
        flag_clr = 1'b0;
        if (wr_now) begin
            case (i_apb.paddr)
                OFF_CTRL: begin
                    nxt.ctrl = i_apb.pwdata[7:0];
                    nxt.ctrl.rsvd = 1'b0;
                end
                OFF_FLAG: begin
                    flag_clr = i_apb.pwdata[FLAG_BIT] && !cur.failsafe;
                end
                OFF_IE: begin
                    nxt.ie = i_apb.pwdata[IE_BIT];
                end
                default: begin
                    nxt.ie = cur.ie;
                end
            endcase
        end
        if (flag_clr) begin
            nxt.flag = 1'b0;
        end
        if (fail) begin
            nxt.flag = 1'b1;
        end
        nxt.irq = nxt.flag && nxt.ie;
        // =================================================================
        // PLL and internal frequency
        nxt.pll_on = i_cfg.config_pll_enable || nxt.ctrl.soft_pll_enable;
        if (!nxt.pll_on) begin
            nxt.pll_cnt = '0;
            nxt.pll_ready = 1'b0;
        end else if (cur.pll_cnt != 15'(PLL_LOCK_CYC - 1)) begin
            nxt.pll_cnt = cur.pll_cnt + 15'h0001;
        end else begin
            nxt.pll_ready = 1'b1;
        end
        nxt.band = band_of(nxt.ctrl.ifs);
        nxt.f32m = (nxt.ctrl.ifs == IFS_32M) && nxt.pll_on;
    end

    // =====================================================================
    // State register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur <= '0;
            cur.ctrl <= CTRL_RST;
        end else begin
            cur <= nxt;
        end
    end
    assign o_apb = cur.rsp;
    assign o_sel_ext = cur.sel_ext;
    assign o_clk_hold = cur.clk_hold;
    assign o_clk_src = cur.src;
    assign o_startup_timeout_status = cur.startup_timeout_status;
    assign o_failsafe = cur.failsafe;
    assign o_cpu_hold = cur.cpu_hold;
    assign o_pll_on = cur.pll_on;
    assign o_pll_ready = cur.pll_ready;
    assign o_freq_sel = cur.ctrl.ifs;
    assign o_band = cur.band;
    assign o_f32m = cur.f32m;
    assign o_irq = cur.irq;

    // =====================================================================
    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    property p_status_set;
        $rose(o_startup_timeout_status) |-> ($past(cur.st) == ST_WAIT_INT) || (cur.st == ST_EXT);
    endproperty
    a_status_set: assert property (p_status_set) else $error("status set out of order");
    property p_hold_then_ext;
        $rose(o_sel_ext) && (o_clk_src == SRC_CFG) && xtal
            |-> ($past(cur.st) == ST_HOLD) && $past(o_clk_hold);
    endproperty
    a_hold_then_ext: assert property (p_hold_then_ext) else $error("switch without hold");
    property p_ost_internal;
        (cur.st == ST_OST) |-> !o_sel_ext && !o_startup_timeout_status && (o_clk_src == SRC_INT);
    endproperty
    a_ost_internal: assert property (p_ost_internal) else $error("external during timer");
    property p_fail_only_ext;
        $rose(o_failsafe) |-> $past(cur.st) == ST_EXT && $past(i_cfg.failsafe_monitor_enable) && !o_sel_ext;
    endproperty
    a_fail_only_ext: assert property (p_fail_only_ext) else $error("failure outside run");
    property p_fail_cause;
        $rose(o_failsafe) |-> $past(samp_fall) && !$past(cur.latch) && !$past(ext_fall);
    endproperty
    a_fail_cause: assert property (p_fail_cause) else $error("failure without cause");
    property p_fail_flag;
        $rose(o_failsafe) |-> cur.flag && (o_clk_src == SRC_INT);
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("flag not set on failure");
    property p_irq;
        o_irq == (cur.flag && cur.ie);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mismatch");
    property p_sleep_clears;
        i_sleep |=> !o_failsafe && !o_startup_timeout_status && (cur.st == ST_SLEEP);
    endproperty
    a_sleep_clears: assert property (p_sleep_clears) else $error("sleep did not clear");
    property p_clear_ignored;
        wr_now && (i_apb.paddr == OFF_FLAG) && cur.failsafe && cur.flag |=> cur.flag;
    endproperty
    a_clear_ignored: assert property (p_clear_ignored) else $error("flag cleared early");
    // The edge that releases reset still registers reset values, so it is skipped.
    property p_pll;
        $past(i_rst_n) |-> o_pll_on == $past(i_cfg.config_pll_enable || nxt.ctrl.soft_pll_enable);
    endproperty
    a_pll: assert property (p_pll) else $error("PLL enable wrong");
    property p_rsvd_zero;
        o_apb.pready && !o_apb.pslverr && ($past(i_apb.paddr) == OFF_CTRL)
            |-> !o_apb.prdata[CTRL_RSVD_BIT];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");
    property p_ready_one;
        i_apb.psel && i_apb.penable && !o_apb.pready |=> o_apb.pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready late");

endmodule

`default_nettype wire

// ---- tsfc_osc_model.sv ----
// Model of the oscillators around the block: crystal or external clock, internal and slow clock.
// Assumes the bench starts and stops the crystal through i_run; the internal clocks run free.
`default_nettype none

module tsfc_osc_model #(
    parameter int EXT_HALF_NS = 400,
    parameter int INT_HALF_NS = 300,
    parameter int LF_HALF_NS = 500
) (
    input wire logic i_run,
    output logic o_ext_clk,
    output logic o_int_clk,
    output logic o_lf_clk
);
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // Clock generation
    initial begin
        o_ext_clk = 1'b0;
        o_int_clk = 1'b0;
        o_lf_clk = 1'b0;
    end

    // A failed crystal simply stops toggling, so the monitor sees no falling edge.
    always #(EXT_HALF_NS) begin
        if (i_run) begin
            o_ext_clk = ~o_ext_clk;
        end
    end

    always #(INT_HALF_NS) o_int_clk = ~o_int_clk;

    always #(LF_HALF_NS) o_lf_clk = ~o_lf_clk;
endmodule

`default_nettype wire

// ---- two_speed_startup_failsafe_clock_tb_top.sv ----
// Self-checking bench for the start-up sequencer, fail-safe monitor and control register.
// Assumes tsfc_top and tsfc_osc_model are compiled before it.
`default_nettype none

module two_speed_startup_failsafe_clock_tb_top;
    import tsfc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // Signals and instances
    localparam int SAMP_HALF_CYC = 32 * 2 * 500 / 100;
    localparam int PLL_SIM_CYC = 8;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    tsfc_apb_req_t i_apb = '0;
    tsfc_apb_rsp_t o_apb;
    tsfc_cfg_t i_cfg = '{1'b1, 1'b1, 1'b0, 1'b0, MODE_XT};
    logic ext_run = 1'b1;
    logic i_ext_clk, i_int_clk, i_lf_clk;
    logic i_powerup_timer_done = 1'b0;
    logic i_sleep = 1'b0;
    logic i_wake = 1'b0;
    logic o_sel_ext, o_clk_hold, o_startup_timeout_status, o_failsafe, o_cpu_hold, o_pll_on;
    logic o_pll_ready, o_f32m, o_irq;
    logic [1:0] o_clk_src;
    logic [3:0] o_freq_sel;
    tsfc_band_t o_band;
    logic [31:0] rdata;
    logic rerr;
    int err_total = 0;
    int checks_done = 0;

    tsfc_osc_model MODEL (.i_run(ext_run), .o_ext_clk(i_ext_clk), .o_int_clk(i_int_clk),
        .o_lf_clk(i_lf_clk));

    tsfc_top #(.PLL_LOCK_CYC(PLL_SIM_CYC)) DUT (.i_mclk, .i_rst_n, .i_apb, .o_apb, .i_cfg,
        .i_ext_clk,
        .i_int_clk, .i_lf_clk, .i_powerup_timer_done, .i_sleep, .i_wake, .o_sel_ext, .o_clk_hold,
        .o_clk_src, .o_startup_timeout_status, .o_failsafe, .o_cpu_hold, .o_pll_on, .o_pll_ready, .o_freq_sel,
        .o_band, .o_f32m, .o_irq);

    always #50 i_mclk = ~i_mclk;

    // =====================================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_apb <= '{1'b1, 1'b0, wr, a, wd};
        @(posedge i_mclk);
        i_apb.penable <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 20);
        rdata = o_apb.prdata;
        rerr = o_apb.pslverr;
        chk(32'(n < 20), 32'h1, "apb answer");
        i_apb <= '0;
        repeat (3) @(negedge i_mclk);
    endtask

    task automatic rst(input tsfc_cfg_t c);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        i_cfg <= c;
        i_powerup_timer_done <= 1'b0;
        repeat (10) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (100) @(negedge i_mclk);
    endtask

    task automatic pulse(input logic slp);
        @(posedge i_mclk);
        if (slp) i_sleep <= 1'b1;
        else i_wake <= 1'b1;
        @(posedge i_mclk);
        i_sleep <= 1'b0;
        i_wake <= 1'b0;
        repeat (2) @(negedge i_mclk);
    endtask

    // Waits until the system clock comes from the external source.
    task automatic wait_ext(output logic held);
        int n;
        n = 0;
        held = 1'b0;
        while (o_sel_ext !== 1'b1 && n < 12000) begin
            @(negedge i_mclk);
            if (o_clk_hold === 1'b1 && o_startup_timeout_status === 1'b1) held = 1'b1;
            n++;
        end
    endtask

    // =====================================================================
    // Scenarios
    task automatic t_regs();
        apb(0, OFF_CTRL, 32'h0);
        chk(rdata, 32'h38, "ctrl reset");
        chk(o_band, BAND_MF, "band reset");
        apb(1, OFF_CTRL, 32'hfc);
        apb(0, OFF_CTRL, 32'h0);
        chk(rdata, 32'hf8, "bit 2 reads zero");
        chk(o_pll_on, 1'b1, "soft pll on");
        chk(o_band, BAND_HF, "band high");
        repeat (PLL_SIM_CYC) @(negedge i_mclk);
        chk(o_pll_ready, 1'b1, "pll ready after lock time");
        apb(1, OFF_CTRL, 32'hf0);
        chk(o_f32m, 1'b1, "32 MHz select");
        apb(1, OFF_CTRL, 32'h08);
        chk(o_band, BAND_LF, "band low");
        apb(1, OFF_CTRL, 32'h38);
        chk(o_pll_on, 1'b0, "soft pll off");
        chk(o_pll_ready, 1'b0, "pll ready drops");
        chk(o_freq_sel, IFS_RST, "freq select");
        apb(0, 8'h10, 32'h0);
        chk(32'(rerr), 32'h1, "unmapped read error");
        chk(rdata, 32'h0, "unmapped read data");
    endtask

    task automatic t_twospeed();
        logic held;
        chk(o_clk_src, SRC_INT, "internal while timer runs");
        chk(o_startup_timeout_status, 1'b0, "status clear while timer runs");
        wait_ext(held);
        chk(held, 1'b1, "hold after status set");
        chk(o_clk_src, SRC_CFG, "external after timer");
        apb(0, OFF_STAT, 32'h0);
        chk(rdata[STAT_STARTUP_TIMEOUT_STATUS], 1'b1, "status bit set");
    endtask

    task automatic t_fail();
        int n;
        logic held;
        apb(1, OFF_IE, 32'h1);
        n = 0;
        ext_run = 1'b0;
        while (o_failsafe !== 1'b1 && n < 2000) begin
            @(negedge i_mclk);
            n++;
        end
        chk(32'(n >= SAMP_HALF_CYC - 20 && n <= 3 * SAMP_HALF_CYC + 20), 1, "fail time");
        chk(o_clk_src, SRC_INT, "fallback to internal");
        chk(o_irq, 1'b1, "fail interrupt");
        apb(1, OFF_FLAG, 32'h1);
        apb(0, OFF_FLAG, 32'h0);
        chk(rdata, 32'h1, "flag kept while fail-safe");
        ext_run = 1'b1;
        repeat (500) @(negedge i_mclk);
        chk(o_clk_src, SRC_INT, "stays internal");
        apb(1, OFF_CTRL, 32'h3a);
        chk(o_failsafe, 1'b0, "select change clears");
        apb(1, OFF_FLAG, 32'h1);
        apb(0, OFF_FLAG, 32'h0);
        chk(rdata, 32'h0, "flag cleared");
        chk(o_irq, 1'b0, "interrupt gone");
        apb(1, OFF_CTRL, 32'h38);
        chk(o_clk_src, SRC_INT, "internal while restarted");
        wait_ext(held);
        chk(o_clk_src, SRC_CFG, "back to external");
    endtask

    task automatic t_sleep();
        logic held;
        pulse(1'b1);
        chk({o_startup_timeout_status, o_sel_ext}, 2'h0, "sleep clears status");
        pulse(1'b0);
        repeat (200) @(negedge i_mclk);
        chk(o_clk_src, SRC_INT, "wake runs internal");
        ext_run = 1'b0;
        repeat (1000) @(negedge i_mclk);
        chk(o_failsafe, 1'b0, "no failure before timer expiry");
        ext_run = 1'b1;
        pulse(1'b1);
        chk(o_startup_timeout_status, 1'b0, "sleep aborts start-up");
        pulse(1'b0);
        wait_ext(held);
        chk(o_startup_timeout_status, 1'b1, "start-up after wake");
    endtask

    task automatic t_cfg();
        int n;
        rst('{1'b0, 1'b0, 1'b0, 1'b0, MODE_XT});
        chk(o_cpu_hold, 1'b1, "no two-speed without switchover");
        rst('{1'b0, 1'b1, 1'b0, 1'b0, MODE_XT});
        chk(o_cpu_hold, 1'b0, "monitor forces two-speed");
        rst('{1'b0, 1'b0, 1'b1, 1'b1, MODE_EC});
        chk(o_sel_ext, 1'b0, "waits for power-up timer");
        chk(o_pll_on, 1'b1, "config pll overrides");
        @(posedge i_mclk);
        i_powerup_timer_done <= 1'b1;
        n = 0;
        while (o_sel_ext !== 1'b1 && n < 50) begin
            @(negedge i_mclk);
            n++;
        end
        chk({o_sel_ext, o_startup_timeout_status}, 2'h3, "external clock skips timer");
        ext_run = 1'b0;
        repeat (1000) @(negedge i_mclk);
        chk(o_failsafe, 1'b0, "monitor off when disabled");
        apb(1, OFF_CTRL, 32'h39);
        chk(o_clk_src, SRC_T1, "timer1 select");
        ext_run = 1'b1;
    endtask

    // =====================================================================
    // Run control
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst('{1'b1, 1'b1, 1'b0, 1'b0, MODE_XT});
        t_regs();
        t_twospeed();
        t_fail();
        t_sleep();
        t_cfg();
        final_report();
    end

    initial begin
        repeat (60000) @(posedge i_mclk);
        err_total++;
        final_report();
    end
endmodule

`default_nettype wire
